// >>> inc/csr_pkg.sv
// constants, types and shared functions of the configuration stream and readback block
package csr_pkg;

  // =====================================================================
  // stream framing
  localparam int FILL_ONES = 8;
  localparam logic [3:0] PREAMBLE_CODE = 4'h2;
  localparam int PREAMBLE_BITS = 4;
  localparam int LEN_BITS = 24;
  localparam int SEP_BITS = 4;
  localparam int CHECK_BITS = 4;
  localparam logic [3:0] CHECK_PATTERN = 4'h6;
  localparam int LAST_CHECK_BITS = 11;
  localparam logic [6:0] POSTAMBLE_CODE = 7'h3F;
  localparam int POSTAMBLE_BITS = 7;

  // =====================================================================
  // start-up and readback
  localparam int STARTUP_STAGES = 5;
  localparam int WAIT_STAGE = 3;
  localparam logic [1:0] DONE_STAGE_DEF = 2'h1;
  localparam logic [1:0] IO_STAGE_DEF = 2'h2;
  localparam logic [1:0] GSR_STAGE_DEF = 2'h3;
  localparam int RB_DUMMY_BITS = 5;
  localparam int RB_PRELOAD_CLKS = 6;
  localparam int RB_HEAD_HIGH = 2;
  localparam int RB_TAIL_HIGH = 7;
  localparam int CRC_W = 11;
  localparam logic [10:0] CRC_POLY = 11'h385;
  localparam logic [10:0] CRC_INIT = 11'h000;

  // =====================================================================
  // types
  typedef enum logic [1:0] {CfgclkFreeRunOpt, CfgclkWaitOnDoneOpt, UserclkFreeRunOpt, UserclkWaitOnDoneOpt}
    csr_startup_type;
  typedef enum logic [3:0] {CfgHunt, CfgPreamble, CfgLength, CfgSeparator, CfgFrameStart, CfgFrameData,
    CfgFrameCheck, CfgPostamble, CfgLoaded, CfgError} csr_cfg_state_type;
  typedef enum logic [2:0] {RbIdle, RbArmed, RbDummy, RbStart, RbData, RbCheck, RbSigStart, RbSig}
    csr_rb_state_type;

  // one serial step of the running check
  function automatic logic [10:0] crcStep(input logic [10:0] crc, input logic bitIn);
    logic fb;
    fb = crc[10] ^ bitIn;
    crcStep = {crc[9:0], 1'b0} ^ (fb ? CRC_POLY : 11'h000);
  endfunction : crcStep

endpackage : csr_pkg

// >>> src/csr_config_loader.sv
// configuration stream checker, start-up sequencer and readback engine
// Operation
// - stream opens with eight ones, preamble 0010, 24-bit length, four separator ones
// - byte input is serialised with parallel bit zero sent first
// - frame starts with zero bit, ends with check field 0110 without CRC
// - CRC mode checks four-bit partial per frame, eleven-bit check on last frame
// - postamble 0111111 marks the end of this device's data
// - check error stops loading and pulls the status line low
// - source supplies extra start-up bytes giving at least four start-up clocks
// - start-up begins when memory full and clock count equals length count
// - next clock edge sets stage zero of five-stage start-up register
// - default order: done release, I/O active next clock, reset release after
// - with configuration clock, stages zero to three give selectable timing
// - optionally stages after the first advance on the user clock
// - wait-on-done options gate stage three with the done line
// - high trigger starts readback; in-progress rises next readback edge
// - readback sends five high dummies, low start, first two bits high
// - check bits high, last seven high, then start bit and 11-bit signature
// - capture latches inverted user state on trigger rising edge
// - without capture, capture positions return loaded configuration values
// - RAM tables read back current RAM contents
// - abort option ends readback on trigger falling edge and rearms
// - readback advances on selected readback clock, configuration clock by default
// - trigger high before completion starts first readback at completion
// - next frame is loaded into shift register on the same readback edge that drives each frame start bit
`timescale 1ns/1ns
module csr_config_loader #(
  parameter int FRAME_BITS = 16,
  parameter int FRAME_COUNT = 4,
  parameter int FIDX_W = 2
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic configClk,
  input wire logic reprogramReq_n,
  input wire logic serialDataIn,
  input wire logic parallelMode,
  input wire logic byteStrobe,
  input wire logic [7:0] byteData,
  input wire logic crcMode,
  output logic statusLineOut,
  output logic statusLineOeN,
  input wire logic doneLineIn,
  output logic doneLineOut,
  output logic doneLineOeN,
  input wire csr_pkg::csr_startup_type startupMode,
  input wire logic [1:0] doneStageSel,
  input wire logic [1:0] ioStageSel,
  input wire logic [1:0] gsrStageSel,
  output logic ioActive,
  output logic globalResetActive,
  output logic configError,
  input wire logic readbackClk,
  input wire logic readbackClkSel,
  input wire logic readbackTrigger,
  input wire logic captureEnable,
  input wire logic abortEnable,
  input wire logic [FRAME_BITS*FRAME_COUNT-1:0] captureMask,
  input wire logic [FRAME_BITS*FRAME_COUNT-1:0] userState,
  input wire logic ramWrEn,
  input wire logic [FIDX_W-1:0] ramWrAddr,
  input wire logic [FRAME_BITS-1:0] ramWrData,
  input wire logic [FRAME_BITS-1:0] ramWrMask,
  output logic readbackData,
  output logic readbackInProgress
);
  localparam logic [FIDX_W-1:0] LAST_FRAME = FIDX_W'(FRAME_COUNT - 1);
  localparam logic [15:0] FRAME_END = 16'(FRAME_BITS - 1);

  // =====================================================================
  // configuration clock domain
  csr_pkg::csr_cfg_state_type cfgState_q;
  logic [15:0] bitCnt_q;
  logic [FIDX_W-1:0] frameCnt_q;
  localparam int LEN_BITS_W = csr_pkg::LEN_BITS;
  logic [LEN_BITS_W-1:0] hdrSr_q;
  logic [LEN_BITS_W-1:0] lengthCount_q;
  logic [LEN_BITS_W-1:0] clkCount_q;
  logic [7:0] byteSr_q;
  logic [FRAME_BITS-1:0] frameWord_q;
  logic [FRAME_BITS-1:0] frameHold_q;
  logic [FIDX_W-1:0] frameHoldIdx_q;
  logic frameTgl_q;
  logic [10:0] cfgCrc_q;
  logic cfgFinished_q;
  logic progCfg;
  logic streamBit;
  logic lastFrame;
  logic [15:0] chkEnd;
  logic chkOk;
  logic chkDone;

  csr_sync2 #(.W(1)) uProgCfgSync (
    .clk(configClk),
    .reset_n(reset_n),
    .d(reprogramReq_n),
    .q(progCfg)
  );

  always_comb
  begin
    streamBit = parallelMode ? (byteStrobe ? byteData[0] : byteSr_q[0]) : serialDataIn;
    lastFrame = (frameCnt_q == LAST_FRAME);
    chkEnd = (crcMode && lastFrame) ? 16'(csr_pkg::LAST_CHECK_BITS - 1) : 16'(csr_pkg::CHECK_BITS - 1);
    chkDone = (cfgState_q == csr_pkg::CfgFrameCheck) && (bitCnt_q == chkEnd);
    if (!crcMode)
      chkOk = ({hdrSr_q[2:0], streamBit} == csr_pkg::CHECK_PATTERN);
    else if (lastFrame)
      chkOk = ({hdrSr_q[9:0], streamBit} == cfgCrc_q);
    else
      chkOk = ({hdrSr_q[2:0], streamBit} == cfgCrc_q[3:0]);
  end

  // byte to serial, low bit first
  always_ff @(posedge configClk or negedge reset_n)
  begin
    if (!reset_n)
      byteSr_q <= 8'hFF;
    else if (byteStrobe)
      byteSr_q <= {1'b1, byteData[7:1]};
    else
      byteSr_q <= {1'b1, byteSr_q[7:1]};
  end

  // =====================================================================
  // stream framing state machine
  always_ff @(posedge configClk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cfgState_q <= csr_pkg::CfgHunt;
      bitCnt_q <= 16'h0000;
      frameCnt_q <= '0;
    end
    else if (!progCfg)
    begin
      cfgState_q <= csr_pkg::CfgHunt;
      bitCnt_q <= 16'h0000;
      frameCnt_q <= '0;
    end
    else
    begin
      bitCnt_q <= bitCnt_q + 16'h0001;
      case (cfgState_q)
        csr_pkg::CfgHunt:
        begin
          if (streamBit)
            bitCnt_q <= (bitCnt_q == 16'(csr_pkg::FILL_ONES)) ? bitCnt_q : bitCnt_q + 16'h0001;
          else if (bitCnt_q == 16'(csr_pkg::FILL_ONES))
            cfgState_q <= csr_pkg::CfgPreamble;
          else
            bitCnt_q <= 16'h0000;
          if (!streamBit && bitCnt_q == 16'(csr_pkg::FILL_ONES))
            bitCnt_q <= 16'h0001;
        end
        csr_pkg::CfgPreamble:
          if (bitCnt_q == 16'(csr_pkg::PREAMBLE_BITS - 1))
          begin
            bitCnt_q <= 16'h0000;
            if ({hdrSr_q[1:0], streamBit} == csr_pkg::PREAMBLE_CODE[2:0])
              cfgState_q <= csr_pkg::CfgLength;
            else
              cfgState_q <= csr_pkg::CfgHunt;
          end
        csr_pkg::CfgLength:
          if (bitCnt_q == 16'(csr_pkg::LEN_BITS - 1))
          begin
            bitCnt_q <= 16'h0000;
            cfgState_q <= csr_pkg::CfgSeparator;
          end
        csr_pkg::CfgSeparator:
          if (!streamBit)
            cfgState_q <= csr_pkg::CfgError;
          else if (bitCnt_q == 16'(csr_pkg::SEP_BITS - 1))
            cfgState_q <= csr_pkg::CfgFrameStart;
        csr_pkg::CfgFrameStart:
        begin
          bitCnt_q <= 16'h0000;
          cfgState_q <= streamBit ? csr_pkg::CfgError : csr_pkg::CfgFrameData;
        end
        csr_pkg::CfgFrameData:
          if (bitCnt_q == FRAME_END)
          begin
            bitCnt_q <= 16'h0000;
            cfgState_q <= csr_pkg::CfgFrameCheck;
          end
        csr_pkg::CfgFrameCheck:
          if (chkDone)
          begin
            bitCnt_q <= 16'h0000;
            frameCnt_q <= frameCnt_q + FIDX_W'(1);
            if (!chkOk)
              cfgState_q <= csr_pkg::CfgError;
            else if (lastFrame)
              cfgState_q <= csr_pkg::CfgPostamble;
            else
              cfgState_q <= csr_pkg::CfgFrameStart;
          end
        csr_pkg::CfgPostamble:
          if (bitCnt_q == 16'(csr_pkg::POSTAMBLE_BITS - 1))
          begin
            if ({hdrSr_q[5:0], streamBit} == csr_pkg::POSTAMBLE_CODE)
              cfgState_q <= csr_pkg::CfgLoaded;
            else
              cfgState_q <= csr_pkg::CfgError;
          end
        default:
          bitCnt_q <= bitCnt_q;
      endcase
    end
  end

  // header window, length count and clocks received since release
  always_ff @(posedge configClk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      hdrSr_q <= '0;
      lengthCount_q <= '0;
      clkCount_q <= '0;
    end
    else if (!progCfg)
    begin
      hdrSr_q <= '0;
      lengthCount_q <= '0;
      clkCount_q <= '0;
    end
    else
    begin
      hdrSr_q <= {hdrSr_q[LEN_BITS_W-2:0], streamBit};
      if (clkCount_q != '1)
        clkCount_q <= clkCount_q + LEN_BITS_W'(1);
      if (cfgState_q == csr_pkg::CfgLength && bitCnt_q == 16'(csr_pkg::LEN_BITS - 1))
        lengthCount_q <= {hdrSr_q[LEN_BITS_W-2:0], streamBit};
    end
  end

  // frame assembly, running check and hand-off to the core domain
  always_ff @(posedge configClk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      frameWord_q <= '0;
      frameHold_q <= '0;
      frameHoldIdx_q <= '0;
      frameTgl_q <= 1'b0;
      cfgCrc_q <= csr_pkg::CRC_INIT;
    end
    else
    begin
      if (cfgState_q == csr_pkg::CfgHunt)
        cfgCrc_q <= csr_pkg::CRC_INIT;
      if (cfgState_q == csr_pkg::CfgFrameData)
      begin
        frameWord_q <= {streamBit, frameWord_q[FRAME_BITS-1:1]};
        cfgCrc_q <= csr_pkg::crcStep(cfgCrc_q, streamBit);
      end
      if (chkDone && chkOk && progCfg)
      begin
        frameHold_q <= frameWord_q;
        frameHoldIdx_q <= frameCnt_q;
        frameTgl_q <= ~frameTgl_q;
      end
    end
  end

  // status line and completion
  always_ff @(posedge configClk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cfgFinished_q <= 1'b0;
      configError <= 1'b0;
      statusLineOut <= 1'b0;
      statusLineOeN <= 1'b1;
    end
    else
    begin
      statusLineOut <= 1'b0;
      configError <= progCfg && (cfgState_q == csr_pkg::CfgError);
      statusLineOeN <= !(progCfg && (cfgState_q == csr_pkg::CfgError));
      if (!progCfg)
        cfgFinished_q <= 1'b0;
      else if (cfgState_q == csr_pkg::CfgLoaded && clkCount_q == lengthCount_q)
        cfgFinished_q <= 1'b1;
    end
  end

  // =====================================================================
  // core clock domain: crossings and edges
  logic [6:0] syncOut;
  logic [3:0] prev_q;
  logic cfgClkRise;
  logic rdClkRise;
  logic trigRise;
  logic trigFall;
  logic frameArrive;
  logic rbTick;
  logic userStartup;
  logic waitOnDone;
  logic [csr_pkg::STARTUP_STAGES-1:0] stage_q;
  logic startupDone;

  csr_sync2 #(.W(7)) uCoreSync (
    .clk(core_clk),
    .reset_n(reset_n),
    .d({configClk, readbackClk, readbackTrigger, doneLineIn, reprogramReq_n, cfgFinished_q, frameTgl_q}),
    .q(syncOut)
  );

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      prev_q <= 4'h0;
    else
      prev_q <= {syncOut[6], syncOut[5], syncOut[4], syncOut[0]};
  end

  always_comb
  begin
    cfgClkRise = syncOut[6] && !prev_q[3];
    rdClkRise = syncOut[5] && !prev_q[2];
    trigRise = syncOut[4] && !prev_q[1];
    trigFall = !syncOut[4] && prev_q[1];
    frameArrive = syncOut[0] ^ prev_q[0];
    rbTick = readbackClkSel ? rdClkRise : cfgClkRise;
    userStartup = (startupMode == csr_pkg::UserclkFreeRunOpt) || (startupMode == csr_pkg::UserclkWaitOnDoneOpt);
    waitOnDone = (startupMode == csr_pkg::CfgclkWaitOnDoneOpt) || (startupMode == csr_pkg::UserclkWaitOnDoneOpt);
    startupDone = ioActive && !globalResetActive;
  end

  // =====================================================================
  // start-up shift register and its three events
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      stage_q <= '0;
    else if (!syncOut[2] || !syncOut[1])
      stage_q <= '0;
    else
    begin
      if (cfgClkRise)
        stage_q[0] <= 1'b1;
      if (userStartup || cfgClkRise)
      begin
        stage_q[1] <= stage_q[0];
        stage_q[2] <= stage_q[1];
        stage_q[csr_pkg::WAIT_STAGE] <= stage_q[2] && (!waitOnDone || syncOut[3]);
        stage_q[4] <= stage_q[3];
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      doneLineOut <= 1'b0;
      doneLineOeN <= 1'b0;
      ioActive <= 1'b0;
      globalResetActive <= 1'b1;
    end
    else
    begin
      doneLineOut <= 1'b0;
      doneLineOeN <= stage_q[doneStageSel];
      ioActive <= stage_q[ioStageSel];
      globalResetActive <= !stage_q[gsrStageSel];
    end
  end

  // =====================================================================
  // frame memory: loader frames first, then user RAM writes
  logic [FIDX_W-1:0] rbFrame_q;
  logic [FRAME_BITS-1:0] memRd;

  csr_frame_mem #(.WIDTH(FRAME_BITS), .DEPTH(FRAME_COUNT), .AW(FIDX_W)) uFrameMem (
    .clk(core_clk),
    .reset_n(reset_n),
    .wrEn(frameArrive || ramWrEn),
    .wrAddr(frameArrive ? frameHoldIdx_q : ramWrAddr),
    .wrData(frameArrive ? frameHold_q : ramWrData),
    .wrMask(frameArrive ? {FRAME_BITS{1'b1}} : ramWrMask),
    .rdAddr(rbFrame_q),
    .rdData(memRd)
  );

  // =====================================================================
  // readback engine
  csr_pkg::csr_rb_state_type rbState_q;
  logic [15:0] rbCnt_q;
  logic [FRAME_BITS-1:0] rbWord_q;
  logic [10:0] rbCrc_q;
  logic [FRAME_BITS*FRAME_COUNT-1:0] capture_q;
  logic rearm_q;
  logic [FRAME_BITS-1:0] maskSlice;
  logic [FRAME_BITS-1:0] loadWord;
  logic forceHigh;

  always_comb
  begin
    maskSlice = captureMask[int'(rbFrame_q)*FRAME_BITS +: FRAME_BITS];
    loadWord = memRd;
    if (captureEnable)
      loadWord = (memRd & ~maskSlice) | (capture_q[int'(rbFrame_q)*FRAME_BITS +: FRAME_BITS] & maskSlice);
    forceHigh = ((rbFrame_q == '0) && (rbCnt_q < 16'(csr_pkg::RB_HEAD_HIGH)))
      || ((rbFrame_q == LAST_FRAME) && (rbCnt_q >= 16'(FRAME_BITS - csr_pkg::RB_TAIL_HIGH)));
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      capture_q <= '0;
    else if (trigRise && captureEnable && startupDone)
      capture_q <= ~userState;
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      rearm_q <= 1'b1;
    else if (rbState_q == csr_pkg::RbIdle && startupDone && syncOut[4] && rearm_q)
      rearm_q <= 1'b0;
    else if (!syncOut[4])
      rearm_q <= 1'b1;
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rbState_q <= csr_pkg::RbIdle;
      rbCnt_q <= 16'h0000;
      rbFrame_q <= '0;
      rbWord_q <= '0;
      rbCrc_q <= csr_pkg::CRC_INIT;
      readbackData <= 1'b1;
      readbackInProgress <= 1'b0;
    end
    else if (!startupDone || (abortEnable && trigFall && rbState_q != csr_pkg::RbIdle))
    begin
      rbState_q <= csr_pkg::RbIdle;
      rbFrame_q <= '0;
      readbackData <= 1'b1;
      readbackInProgress <= 1'b0;
    end
    else if (rbState_q == csr_pkg::RbIdle)
    begin
      rbFrame_q <= '0;
      rbCrc_q <= csr_pkg::CRC_INIT;
      if (syncOut[4] && rearm_q)
        rbState_q <= csr_pkg::RbArmed;
    end
    else if (rbTick)
    begin
      rbCnt_q <= rbCnt_q + 16'h0001;
      case (rbState_q)
        csr_pkg::RbArmed:
        begin
          readbackInProgress <= 1'b1;
          rbCnt_q <= 16'h0000;
          rbState_q <= csr_pkg::RbDummy;
        end
        csr_pkg::RbDummy:
        begin
          readbackData <= 1'b1;
          if (rbCnt_q == 16'(csr_pkg::RB_DUMMY_BITS - 1))
            rbState_q <= csr_pkg::RbStart;
        end
        csr_pkg::RbStart:
        begin
          readbackData <= 1'b0;
          rbWord_q <= loadWord;
          rbCnt_q <= 16'h0000;
          rbState_q <= csr_pkg::RbData;
        end
        csr_pkg::RbData:
        begin
          readbackData <= rbWord_q[0] || forceHigh;
          rbCrc_q <= csr_pkg::crcStep(rbCrc_q, rbWord_q[0] || forceHigh);
          rbWord_q <= {1'b1, rbWord_q[FRAME_BITS-1:1]};
          if (rbCnt_q == FRAME_END)
          begin
            rbCnt_q <= 16'h0000;
            rbState_q <= csr_pkg::RbCheck;
          end
        end
        csr_pkg::RbCheck:
        begin
          readbackData <= 1'b1;
          if (rbCnt_q == 16'(csr_pkg::CHECK_BITS - 1))
          begin
            if (rbFrame_q == LAST_FRAME)
              rbState_q <= csr_pkg::RbSigStart;
            else
              rbState_q <= csr_pkg::RbStart;
          end
          if (rbCnt_q == 16'(csr_pkg::CHECK_BITS - 1) && rbFrame_q != LAST_FRAME)
            rbFrame_q <= rbFrame_q + FIDX_W'(1);
        end
        csr_pkg::RbSigStart:
        begin
          readbackData <= 1'b0;
          rbCnt_q <= 16'h0000;
          rbState_q <= csr_pkg::RbSig;
        end
        csr_pkg::RbSig:
        begin
          if (rbCnt_q == 16'(csr_pkg::CRC_W))
          begin
            readbackData <= 1'b1;
            readbackInProgress <= 1'b0;
            rbState_q <= csr_pkg::RbIdle;
          end
          else
            readbackData <= rbCrc_q[4'(csr_pkg::CRC_W - 1) - rbCnt_q[3:0]];
        end
        default:
          rbState_q <= csr_pkg::RbIdle;
      endcase
    end
  end
endmodule : csr_config_loader

// >>> src/csr_frame_mem.sv
// frame memory with bit-masked write and registered read
`timescale 1ns/1ns
module csr_frame_mem #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4,
  parameter int AW = 2
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic wrEn,
  input wire logic [AW-1:0] wrAddr,
  input wire logic [WIDTH-1:0] wrData,
  input wire logic [WIDTH-1:0] wrMask,
  input wire logic [AW-1:0] rdAddr,
  output logic [WIDTH-1:0] rdData
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk)
  begin
    if (wrEn)
      mem[wrAddr] <= (mem[wrAddr] & ~wrMask) | (wrData & wrMask);
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      rdData <= '0;
    else
      rdData <= mem[rdAddr];
  end
endmodule : csr_frame_mem

// >>> src/csr_sync2.sv
// two-flop level synchroniser, one per bit
`timescale 1ns/1ns
module csr_sync2 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      meta_q <= '0;
      q <= '0;
    end
    else
    begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule : csr_sync2

// >>> verification/csr_config_loader_tb.sv
// testbench for the configuration loader
`timescale 1ns/1ns
module csr_config_loader_tb;
  logic core_clk = 1'h0, reset_n = 1'h0, reprogramReq_n = 1'h1, parallelMode = 1'h0, byteStrobe = 1'h0;
  logic crcMode = 1'h0, readbackClk = 1'h0, readbackClkSel = 1'h1, readbackTrigger = 1'h0;
  logic captureEnable = 1'h0, abortEnable = 1'h0, ramWrEn = 1'h0;
  logic [7:0] byteData = 8'h00;
  logic [63:0] captureMask = 64'h0, userState = 64'h0;
  logic [1:0] ramWrAddr = 2'h0;
  logic [15:0] ramWrData = 16'h0, ramWrMask = 16'h0;
  logic [1:0] doneStageSel = csr_pkg::DONE_STAGE_DEF, ioStageSel = csr_pkg::IO_STAGE_DEF;
  logic [1:0] gsrStageSel = csr_pkg::GSR_STAGE_DEF;
  csr_pkg::csr_startup_type startupMode = csr_pkg::CfgclkFreeRunOpt;
  logic configClk, serialDataIn, statusLineOut, statusLineOeN, doneLineOut, doneLineOeN, doneLineIn;
  logic ioActive, globalResetActive, configError, readbackData, readbackInProgress;
  int err_total = 0, comparisons = 0;
  assign doneLineIn = doneLineOeN ? 1'h1 : doneLineOut;
  always #2 core_clk = ~core_clk;
  initial #1 forever #32 readbackClk = ~readbackClk;
  csr_stream_source src (.configClk, .serialDataIn);
  csr_config_loader uut (.core_clk, .reset_n, .configClk, .reprogramReq_n, .serialDataIn, .parallelMode,
    .byteStrobe, .byteData, .crcMode, .statusLineOut, .statusLineOeN, .doneLineIn, .doneLineOut, .doneLineOeN,
    .startupMode, .doneStageSel, .ioStageSel, .gsrStageSel, .ioActive, .globalResetActive, .configError,
    .readbackClk, .readbackClkSel, .readbackTrigger, .captureEnable, .abortEnable, .captureMask, .userState,
    .ramWrEn, .ramWrAddr, .ramWrData, .ramWrMask, .readbackData, .readbackInProgress);
  // ==========
  // helpers
  function automatic logic [191:0] mkStream(input logic [3:0] chk);
    logic [20:0] fr;
    fr = {1'h0, 16'h1234, chk};
    mkStream = {3'h7, 8'hFF, csr_pkg::PREAMBLE_CODE, 24'h96, 4'hF, fr, fr, fr, fr, csr_pkg::POSTAMBLE_CODE,
      {58{1'h1}}};
  endfunction : mkStream
  task automatic cmp(input string nm, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : cmp
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  task automatic do_reset;
    @(posedge core_clk) reset_n <= 1'h0;
    src.send({192{1'h1}}, 3);
    repeat (20) @(posedge core_clk);
    reset_n <= 1'h1;
  endtask : do_reset
  // ==========
  // scenarios
  task automatic t_bad;
    src.send(mkStream(4'h7) >> 122, 70);
    cmp("err flags", 8'h02, {6'h0, configError, statusLineOeN});
    src.send({192{1'h1}}, 80);
    cmp("err held", 8'h04, {5'h0, configError, doneLineOeN, ioActive});
    @(posedge core_clk) reprogramReq_n <= 1'h0;
    src.send({192{1'h1}}, 4);
    @(posedge core_clk) reprogramReq_n <= 1'h1;
    src.send({192{1'h1}}, 4);
    cmp("err cleared", 8'h01, {6'h0, configError, statusLineOeN});
    $display("t_bad finished");
  endtask : t_bad
  task automatic t_good;
    int n;
    logic [7:0] bits;
    src.send(mkStream(csr_pkg::CHECK_PATTERN), 192);
    repeat (20) @(posedge core_clk);
    cmp("startup", 8'h0C, {4'h0, doneLineOeN, ioActive, globalResetActive, configError});
    @(posedge core_clk) readbackTrigger <= 1'h1;
    n = 0;
    while (readbackInProgress !== 1'h1 && n < 500)
    begin
      @(posedge core_clk);
      n++;
    end
    cmp("rip rise", 8'h01, {7'h0, readbackInProgress});
    for (int i = 0; i < 9; i++)
    begin
      @(negedge readbackClk);
      bits = {bits[6:0], readbackData};
    end
    cmp("rb head", 8'hFB, bits);
    @(posedge core_clk) readbackTrigger <= 1'h0;
    n = 0;
    while (readbackInProgress !== 1'h0 && n < 5000)
    begin
      @(posedge core_clk);
      n++;
    end
    cmp("rb end", 8'h01, {6'h0, readbackInProgress, readbackData});
    @(posedge core_clk) {abortEnable, readbackTrigger} <= 2'h3;
    repeat (100) @(posedge core_clk);
    cmp("abort start", 8'h01, {7'h0, readbackInProgress});
    readbackTrigger <= 1'h0;
    repeat (8) @(posedge core_clk);
    cmp("aborted", 8'h01, {6'h0, readbackInProgress, readbackData});
    $display("t_good finished");
  endtask : t_good
  initial
  begin
    do_reset();
    t_bad();
    do_reset();
    t_good();
    give_verdict();
  end
  initial
  begin
    #300000;
    err_total++;
    give_verdict();
  end
endmodule : csr_config_loader_tb
bind csr_config_loader csr_loader_checker chk_i (.core_clk, .reset_n, .configClk, .reprogramReq_n,
  .statusLineOut, .statusLineOeN, .doneLineOut, .doneLineOeN, .ioActive, .globalResetActive, .configError,
  .readbackData, .readbackInProgress);

// >>> verification/csr_loader_checker.sv
// port assertions for the configuration loader
`timescale 1ns/1ns
module csr_loader_checker (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic configClk,
  input wire logic reprogramReq_n,
  input wire logic statusLineOut,
  input wire logic statusLineOeN,
  input wire logic doneLineOut,
  input wire logic doneLineOeN,
  input wire logic ioActive,
  input wire logic globalResetActive,
  input wire logic configError,
  input wire logic readbackData,
  input wire logic readbackInProgress
);
  // ==========
  // properties
  property p_errPull;
    @(posedge configClk) disable iff (!reset_n) configError |-> !statusLineOeN;
  endproperty
  a_errPull: assert property (p_errPull) else $error("status not pulled");
  property p_errHold;
    @(posedge configClk) disable iff (!reset_n)
      configError && reprogramReq_n && $past(reprogramReq_n, 3) |=> configError;
  endproperty
  a_errHold: assert property (p_errHold) else $error("error dropped");
  property p_pinsLow;
    @(posedge core_clk) disable iff (!reset_n) !statusLineOut && !doneLineOut;
  endproperty
  a_pinsLow: assert property (p_pinsLow) else $error("open drain drives high");
  property p_errStop;
    @(posedge core_clk) disable iff (!reset_n) configError |-> !ioActive && globalResetActive;
  endproperty
  a_errStop: assert property (p_errStop) else $error("start-up after error");
  property p_doneFirst;
    @(posedge core_clk) disable iff (!reset_n) $rose(ioActive) |-> doneLineOeN;
  endproperty
  a_doneFirst: assert property (p_doneFirst) else $error("io before done");
  property p_gsrLast;
    @(posedge core_clk) disable iff (!reset_n) $fell(globalResetActive) |-> ioActive && doneLineOeN;
  endproperty
  a_gsrLast: assert property (p_gsrLast) else $error("reset released early");
  property p_idle;
    @(posedge core_clk) disable iff (!reset_n) !ioActive || globalResetActive |-> !readbackInProgress;
  endproperty
  a_idle: assert property (p_idle) else $error("readback before start-up");
  property p_dataIdle;
    @(posedge core_clk) disable iff (!reset_n) !readbackInProgress |-> readbackData;
  endproperty
  a_dataIdle: assert property (p_dataIdle) else $error("idle data low");
  property p_dummy;
    @(posedge core_clk) disable iff (!reset_n) $rose(readbackInProgress) |-> readbackData [*8];
  endproperty
  a_dummy: assert property (p_dummy) else $error("dummy bit low");
  c_rip: cover property (@(posedge core_clk) $rose(readbackInProgress));
  c_err: cover property (@(posedge configClk) $rose(configError));
  c_up: cover property (@(posedge core_clk) $fell(globalResetActive));
endmodule : csr_loader_checker

// >>> verification/csr_stream_source.sv
// configuration source model: serial bits on a gated clock
`timescale 1ns/1ns
module csr_stream_source (
  output logic configClk,
  output logic serialDataIn
);
  initial
  begin
    configClk = 1'h0;
    serialDataIn = 1'h1;
  end
  // ==========
  // msb first, clock runs only while bits flow
  task automatic send(input logic [191:0] v, input int n);
    for (int i = n - 1; i >= 0; i--)
    begin
      serialDataIn = v[i];
      #15 configClk = 1'h1;
      #15 configClk = 1'h0;
    end
    serialDataIn = ~serialDataIn;
  endtask : send
endmodule : csr_stream_source
